// file: rtl/cxs_core.sv
// Execute stage: AND, bit-test skips, clears, call and watchdog clear
`timescale 1ns/1ps
`include "cxs_cfg.svh"
module cxs_core #(
	parameter int PCW = 11,
	parameter int STACK_DEPTH = 2,
	parameter int WDOG_W = 8,
	parameter int PRE_W = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	output logic [PCW-1:0] prog_addr,
	input wire logic [11:0] prog_data,
	input wire logic [1:0] page_bits,
	input wire logic prescaler_to_watchdog,
	output logic [7:0] accumulator,
	output logic zero_flag,
	output logic time_out_flag,
	output logic power_down_flag,
	output logic [WDOG_W-1:0] watchdog_counter,
	output logic [PRE_W-1:0] prescaler,
	output logic [PCW-1:0] stack_top,
	output logic skip_taken
);
	// ==========================================
	// State
	logic [PCW-1:0] program_counter, next_prog_cnt;
	logic [11:0] ir, next_ir;
	logic [7:0] next_w;
	logic next_z, next_time_out, next_power_down, next_skip;
	logic [WDOG_W-1:0] next_wdog;
	logic [PRE_W-1:0] next_pre;
	logic [PCW-1:0] stack [STACK_DEPTH];
	logic [PCW-1:0] next_stack [STACK_DEPTH];
	cxs_pkg::cxs_op_e op;
	logic [7:0] fr_rdata, fr_wdata, and_res;
	logic fr_we, sel_bit;
	logic [4:0] faddr;

	assign faddr = ir[`CXS_FILE_HI:0];
	assign sel_bit = fr_rdata[ir[`CXS_BIT_HI:`CXS_BIT_LO]];
	assign and_res = accumulator & fr_rdata;

	cxs_fregs #(.DEPTH(32), .WIDTH(8), .AW(5)) u_fregs (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.raddr(faddr),
		.rdata(fr_rdata),
		.we(fr_we),
		.waddr(faddr),
		.wdata(fr_wdata)
	);

	// ==========================================
	// Decode
	always_comb begin
		op = cxs_pkg::OP_NOP;
		if (ir[11:6] == `CXS_TOP_AND) begin
			op = cxs_pkg::OP_AND;
		end else if (ir[11:8] == `CXS_NIB_BTC) begin
			op = cxs_pkg::OP_BTC;
		end else if (ir[11:8] == `CXS_NIB_BTS) begin
			op = cxs_pkg::OP_BTS;
		end else if (ir == `CXS_OPC_ACC_CLR) begin
			op = cxs_pkg::OP_ACC_CLR;
		end else if (ir[11:5] == `CXS_TOP_FILE_CLR) begin
			op = cxs_pkg::OP_FILE_CLR;
		end else if (ir[11:8] == `CXS_NIB_CALL) begin
			op = cxs_pkg::OP_CALL;
		end else if (ir == `CXS_OPC_WDOG_CLR) begin
			op = cxs_pkg::OP_WDOG_CLR;
		end
	end

	// ==========================================
	// Execute
	// Unlisted opcodes fall through as no-ops; other units own them
	always_comb begin
		next_prog_cnt = program_counter + PCW'(1);
		next_ir = prog_data;
		next_w = accumulator;
		next_z = zero_flag;
		next_time_out = time_out_flag;
		next_power_down = power_down_flag;
		next_skip = 1'b0;
		next_stack = stack;
		fr_we = 1'b0;
		fr_wdata = and_res;
		next_pre = prescaler + PRE_W'(1);
		next_wdog = watchdog_counter;
		if (!prescaler_to_watchdog || prescaler == '1) begin
			next_wdog = watchdog_counter + WDOG_W'(1);
		end
		case (op)
			cxs_pkg::OP_AND: begin
				if (ir[`CXS_DEST_BIT]) begin
					fr_we = 1'b1;
				end else begin
					next_w = and_res;
				end
				next_z = (and_res == 8'h00);
			end
			cxs_pkg::OP_BTC, cxs_pkg::OP_BTS: begin
				// Prefetched word is dropped, so the skip costs a second cycle
				if (sel_bit == (op == cxs_pkg::OP_BTS)) begin
					next_ir = `CXS_OPC_NOP;
					next_skip = 1'b1;
				end
			end
			cxs_pkg::OP_ACC_CLR: begin
				next_w = 8'h00;
				next_z = 1'b1;
			end
			cxs_pkg::OP_FILE_CLR: begin
				fr_we = 1'b1;
				fr_wdata = 8'h00;
				next_z = 1'b1;
			end
			cxs_pkg::OP_CALL: begin
				// Program counter already holds call address plus one
				next_stack[0] = program_counter;
				for (int i = 1; i < STACK_DEPTH; i++) begin
					next_stack[i] = stack[i-1];
				end
				next_prog_cnt = PCW'({page_bits, 1'b0, ir[`CXS_LIT_HI:0]});
				next_ir = `CXS_OPC_NOP;
			end
			cxs_pkg::OP_WDOG_CLR: begin
				next_wdog = '0;
				if (prescaler_to_watchdog) begin
					next_pre = '0;
				end
				next_time_out = 1'b1;
				next_power_down = 1'b1;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			program_counter <= `CXS_RST_PROG_CNT;
			ir <= `CXS_OPC_NOP;
			accumulator <= `CXS_RST_W;
			zero_flag <= 1'b0;
			time_out_flag <= `CXS_RST_FLAGS;
			power_down_flag <= `CXS_RST_FLAGS;
			watchdog_counter <= '0;
			prescaler <= '0;
			skip_taken <= 1'b0;
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack[i] <= '0;
			end
		end else if (ce) begin
			program_counter <= next_prog_cnt;
			ir <= next_ir;
			accumulator <= next_w;
			zero_flag <= next_z;
			time_out_flag <= next_time_out;
			power_down_flag <= next_power_down;
			watchdog_counter <= next_wdog;
			prescaler <= next_pre;
			skip_taken <= next_skip;
			stack <= next_stack;
		end
	end

	assign prog_addr = program_counter;
	assign stack_top = stack[0];

	// ==========================================
	// Checks
	a_and_to_acc: assert property (@(posedge mclk) disable iff (rst)
		ce && op == cxs_pkg::OP_AND && !ir[`CXS_DEST_BIT] |=>
		accumulator == $past(and_res) && zero_flag == ($past(and_res) == 8'h00))
		else $error("AND result not in accumulator");
	a_and_to_file: assert property (@(posedge mclk) disable iff (rst)
		ce && op == cxs_pkg::OP_AND && ir[`CXS_DEST_BIT] |->
		fr_we && fr_wdata == (accumulator & fr_rdata) ##1 accumulator == $past(accumulator))
		else $error("AND result not routed to file");
	a_skip_clear: assert property (@(posedge mclk) disable iff (rst)
		ce && op == cxs_pkg::OP_BTC && !sel_bit |=> ir == `CXS_OPC_NOP && skip_taken)
		else $error("Clear skip not taken");
	a_skip_set: assert property (@(posedge mclk) disable iff (rst)
		ce && op == cxs_pkg::OP_BTS |=> skip_taken == $past(sel_bit)
		&& zero_flag == $past(zero_flag))
		else $error("Set skip wrong");
	a_clr_acc: assert property (@(posedge mclk) disable iff (rst)
		ce && op == cxs_pkg::OP_ACC_CLR |=> accumulator == 8'h00 && zero_flag)
		else $error("Accumulator clear wrong");
	a_clr_file: assert property (@(posedge mclk) disable iff (rst)
		ce && op == cxs_pkg::OP_FILE_CLR |-> fr_we && fr_wdata == 8'h00 ##1 zero_flag)
		else $error("File clear wrong");
	a_call_target: assert property (@(posedge mclk) disable iff (rst)
		ce && op == cxs_pkg::OP_CALL |=> program_counter ==
		{$past(page_bits), 1'b0, $past(ir[7:0])} && stack_top == $past(program_counter))
		else $error("Call target or push wrong");
	a_call_two_cycle: assert property (@(posedge mclk) disable iff (rst)
		ce && op == cxs_pkg::OP_CALL |=> ir == `CXS_OPC_NOP && $stable(zero_flag)
		&& $stable(time_out_flag) && $stable(power_down_flag))
		else $error("Call not two cycles or flags moved");
	a_wdog_clear: assert property (@(posedge mclk) disable iff (rst)
		ce && op == cxs_pkg::OP_WDOG_CLR |=> watchdog_counter == '0
		&& (!$past(prescaler_to_watchdog) || prescaler == '0))
		else $error("Watchdog clear wrong");
	a_wdog_flags: assert property (@(posedge mclk) disable iff (rst)
		ce && op == cxs_pkg::OP_WDOG_CLR |=> time_out_flag && power_down_flag)
		else $error("Status flags not set");
	a_call_shift: assert property (@(posedge mclk) disable iff (rst)
		ce && op == cxs_pkg::OP_CALL |=> stack[1] == $past(stack[0]))
		else $error("Return stack did not shift");
	a_skip_flags: assert property (@(posedge mclk) disable iff (rst)
		ce && (op == cxs_pkg::OP_BTC || op == cxs_pkg::OP_BTS) |=> $stable(zero_flag)
		&& $stable(accumulator) && $stable(time_out_flag) && $stable(power_down_flag))
		else $error("Bit test changed flags");
	// Hidden word is still fetched; only its execution is dropped
	a_skip_advance: assert property (@(posedge mclk) disable iff (rst)
		ce && op == cxs_pkg::OP_BTC && !sel_bit |=>
		program_counter == $past(program_counter) + PCW'(1))
		else $error("Skip did not step past the hidden word");
endmodule

// file: rtl/cxs_cfg.svh
// Constants for the core execute and skip/call/clear unit
// Function
// - AND accumulator with file, route, zero flag
// - Skip-if-clear tests file bit b
// - Taken skip discards prefetch, runs no-op
// - Skip-if-set skips when bit is one
// - Accumulator clear loads zero, sets zero flag
// - Call pushes return address onto stack
// - Call loads literal, clears bit8, page bits
// - Call takes two cycles, flags untouched
// - Watchdog clear zeroes counter, prescaler if assigned
// - Watchdog clear sets time-out and power-down flags
// - File clear writes zero, sets zero flag
// - Skip-if-clear opcode top nibble 0110
// - Skip-if-set opcode top nibble 0111
// - Watchdog clear opcode is 0000 0000 0100
`ifndef CXS_CFG_SVH
`define CXS_CFG_SVH

// ==========================================
// Opcode encodings
`define CXS_OPC_NOP 12'h000
`define CXS_OPC_ACC_CLR 12'h040
`define CXS_OPC_WDOG_CLR 12'h004
`define CXS_TOP_AND 6'h05
`define CXS_TOP_FILE_CLR 7'h03
`define CXS_NIB_BTC 4'h6
`define CXS_NIB_BTS 4'h7
`define CXS_NIB_CALL 4'h9

// ==========================================
// Field positions
`define CXS_DEST_BIT 5
`define CXS_BIT_HI 7
`define CXS_BIT_LO 5
`define CXS_FILE_HI 4
`define CXS_LIT_HI 7

// ==========================================
// Reset values
`define CXS_RST_PROG_CNT 11'h000
`define CXS_RST_W 8'h00
`define CXS_RST_FLAGS 1'b1

`endif

// file: rtl/cxs_pkg.sv
// Types for the core execute and skip/call/clear unit
package cxs_pkg;
	typedef enum logic [2:0] {
		OP_NOP,
		OP_AND,
		OP_BTC,
		OP_BTS,
		OP_ACC_CLR,
		OP_FILE_CLR,
		OP_CALL,
		OP_WDOG_CLR
	} cxs_op_e;
endpackage

// file: rtl/cxs_fregs.sv
// File register storage, one combinational read port and one write port
`timescale 1ns/1ps
module cxs_fregs #(
	parameter int DEPTH = 32,
	parameter int WIDTH = 8,
	parameter int AW = 5
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	// ==========================================
	// Storage
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_ent
			logic [WIDTH-1:0] next_ent;
			always_comb begin
				next_ent = mem[gi];
				if (we && waddr == AW'(gi)) begin
					next_ent = wdata;
				end
			end
			always_ff @(posedge mclk) begin
				if (rst) begin
					mem[gi] <= '0;
				end else if (ce) begin
					mem[gi] <= next_ent;
				end
			end
		end
	endgenerate

	assign rdata = mem[raddr];
endmodule

// file: test/cxs_prog_mem.sv
// Program memory model that feeds the execute unit
`timescale 1ns/1ps
module cxs_prog_mem (
	input wire logic [10:0] addr,
	output logic [11:0] data
);
	// ==========================================
	// Storage
	logic [11:0] mem [0:2048-1];
	// Combinational read; blank words hold the no-op code so runaway fetches stay harmless
	assign data = mem[addr];
endmodule

// file: test/test_core_instr_exec_and_skip_call_clear.sv
// Self-checking bench for the execute unit
`timescale 1ns/1ps
module test_core_instr_exec_and_skip_call_clear;
	// ==========================================
	// Signals
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic prescaler_to_watchdog = 1'b0;
	logic [1:0] page_bits = 2'h0;
	logic [10:0] prog_addr;
	logic [10:0] stack_top;
	logic [11:0] prog_data;
	logic [7:0] accumulator;
	logic [7:0] watchdog_counter;
	logic [7:0] prescaler;
	logic zero_flag;
	logic time_out_flag;
	logic power_down_flag;
	logic skip_taken;
	int failures = 0;
	int tests_run = 0;

	always #2.5 mclk = ~mclk;

	cxs_prog_mem pm (.addr(prog_addr), .data(prog_data));

	cxs_core dut (.mclk(mclk), .rst(rst), .ce(ce), .prog_addr(prog_addr),
		.prog_data(prog_data), .page_bits(page_bits),
		.prescaler_to_watchdog(prescaler_to_watchdog), .accumulator(accumulator),
		.zero_flag(zero_flag), .time_out_flag(time_out_flag),
		.power_down_flag(power_down_flag), .watchdog_counter(watchdog_counter),
		.prescaler(prescaler), .stack_top(stack_top), .skip_taken(skip_taken));

	// ==========================================
	// Helpers
	task automatic check(logic [15:0] seen, logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// File registers only clear on reset, so every program starts from a fresh reset
	task automatic load(logic [11:0] w0, logic [11:0] w1);
		for (int i = 0; i < 2048; i++) begin
			pm.mem[i] = 12'h000;
		end
		pm.mem[0] = w0;
		pm.mem[1] = w1;
		rst = 1'b1;
		repeat (10) @(negedge mclk);
		rst = 1'b0;
	endtask

	task automatic step(int n);
		repeat (n) @(negedge mclk);
	endtask

	// ==========================================
	// Scenarios
	// Clears and zero results set the zero flag; an unlisted code leaves it alone
	task automatic t_zero();
		logic [11:0] ops [5] = '{12'h040, 12'h063, 12'h141, 12'h17F, 12'h002};
		for (int i = 0; i < 5; i++) begin
			load(ops[i], 12'h000);
			step(1);
			check(zero_flag, 1'b0);
			step(1);
			check(zero_flag, (i < 4));
			check(accumulator, 8'h00);
		end
	endtask

	// A taken skip hides the next word; an untaken one lets it run
	task automatic t_skip();
		load(12'h6FF, 12'h040);
		step(2);
		check(skip_taken, 1'b1);
		check(prog_addr, 11'h002);
		step(1);
		check(skip_taken, 1'b0);
		check(zero_flag, 1'b0);
		load(12'h7FF, 12'h040);
		step(2);
		check(skip_taken, 1'b0);
		step(1);
		check(zero_flag, 1'b1);
	endtask

	task automatic t_call();
		page_bits = 2'h3;
		load(12'h9A5, 12'h040);
		pm.mem[11'h6A5] = 12'h040;
		step(2);
		check(prog_addr, 11'h6A5);
		check(stack_top, 11'h001);
		step(1);
		check(zero_flag, 1'b0);
		step(1);
		check(zero_flag, 1'b1);
	endtask

	// The prescaler only clears when it serves the watchdog
	task automatic t_wdog();
		for (int a = 0; a < 2; a++) begin
			prescaler_to_watchdog = a[0];
			load(12'h000, 12'h000);
			pm.mem[5] = 12'h004;
			step(7);
			check(watchdog_counter, 8'h00);
			check(prescaler, (a == 1) ? 8'h00 : 8'h07);
			check(time_out_flag, 1'b1);
			check(power_down_flag, 1'b1);
		end
	endtask

	// Clock enable low freezes fetch, counters and flags
	task automatic t_hold();
		load(12'h040, 12'h000);
		ce = 1'b0;
		step(3);
		check(prog_addr, 11'h000);
		check(prescaler, 8'h00);
		check(zero_flag, 1'b0);
		ce = 1'b1;
		step(2);
		check(prog_addr, 11'h002);
		check(prescaler, 8'h02);
		check(zero_flag, 1'b1);
	endtask

	// ==========================================
	// Verdict
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		t_zero();
		t_skip();
		t_call();
		t_wdog();
		t_hold();
		final_report();
	end
endmodule
